// ---- hw/css_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronised active-low reset; DEPTH is a power of two.
`timescale 1ns/1ps
module css_fifo #(
    parameter int W     = 8,                      // Word width
    parameter int DEPTH = 8                       // Number of words
) (
    input  wire logic         clock,              // User clock
    input  wire logic         rst_sync_b,         // Synchronised reset, active low
    input  wire logic         in_valid,           // Write request
    output logic              in_ready,           // Space available, registered
    input  wire logic [W-1:0] in_data,            // Write word
    output logic              out_valid,          // Word available
    input  wire logic         out_ready,          // Reader takes word
    output logic [W-1:0]      out_data            // Head word
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [AW:0]   next_count;
    logic          wr_go;
    logic          rd_go;

    // ------------------------------------------------------------
    // Handshakes and occupancy
    // ------------------------------------------------------------
    assign wr_go      = in_valid && in_ready;
    assign rd_go      = out_valid && out_ready;
    assign out_valid  = (count != '0);
    assign out_data   = mem[rd_ptr];
    assign next_count = count + (AW+1)'(wr_go) - (AW+1)'(rd_go);

    // Count and a registered ready, so the source never sees a combinational path
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            count    <= '0;
            in_ready <= 1'b1;
        end else begin
            count    <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end

    // Pointers wrap naturally at a power-of-two depth
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (wr_go) wr_ptr <= wr_ptr + 1'b1;
            if (rd_go) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // Storage needs no reset; nothing reads an empty slot
    always_ff @(posedge clock) begin
        if (wr_go) mem[wr_ptr] <= in_data;
    end

endmodule // css_fifo

// ---- hw/css_framer.sv ----
// Completion stream output stage: buffers beats, frames them and drives the
// user-facing valid/ready stream with its sideband word.
// Assumes the completion engine shares the clock and fills pay*/eof* fields.
//
// Behaviour
// (RL1) A beat moves only when valid and ready are both high.
// (RL2) While valid waits on ready, data, sideband and valid hold steady.
// (RL3) User logic raises ready to accept and may drop it to pace.
// (RL4) Byte enable bit i set exactly when byte i is payload.
// (RL5) No byte enable on descriptor bytes.
// (RL6) Payload byte enables of one TLP form one contiguous run.
// (RL7) Byte enables above the configured width stay zero.
// (RL8) Zero-length read completions still carry a byte enable.
// (RL9) Without straddle, first start flag marks each packet's first beat.
// (RL10) Without straddle, one start per beat, second start flag zero.
// (RL11) Without straddle, user logic may ignore the first start flag.
// (RL12) Straddle at 256 bits may carry two TLPs, not stream-framed.
// (RL13) Straddled first start is lane 0, or lane 16 if prior continues.
// (RL14) Second start at lane 16 only when first TLP ended this beat.
// (RL15) Valid rises whenever buffered data waits and holds through stalls.
// (RL16) User logic reads sideband only while valid is high.
// (RL17) First end field bit 0 marks a first TLP ending, straddle only.
// (RL18) Width and straddle are build-time parameters, never changed live.
`timescale 1ns/1ps
module css_framer
    import css_pkg::*;
#(
    parameter int DATA_W   = css_pkg::DEF_DATA_W, // 64, 128 or 256
    parameter bit STRADDLE = 1'b0,                // Straddle option
    parameter int DEPTH    = css_pkg::FIFO_DEPTH  // Buffer depth in beats
) (
    input  wire logic                          clock,               // User clock
    input  wire logic                          rst_b,               // Async reset, active low
    input  wire logic                          in_valid,            // Engine offers a beat
    output logic                               in_ready,            // Buffer can take a beat
    input  wire css_pkg::css_beat_t            in_beat,             // Beat from the engine
    input  wire logic                          cpl_out_ready,       // User accepts beat
    output logic                               cpl_out_valid,       // Beat on the bus
    output logic [css_pkg::MAX_DATA_W-1:0]     cpl_out_payload_bus, // Data bus
    output logic [7:0]                         cpl_out_keep,        // Dword keep
    output logic                               cpl_out_last,        // End of packet
    output css_pkg::css_sband_t                cpl_out_sideband     // Sideband word
);
    import css_pkg::*;

    // Straddle exists only on the widest bus; both are fixed at build time [RL18]
    localparam bit STRAD_ON = STRADDLE && (DATA_W == MAX_DATA_W);   // [RL12]
    localparam int BYTES    = DATA_W / 8;
    localparam int DWORDS   = DATA_W / 32;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic       rst_sync_b;

    // Assert at once, release after two edges so all flops leave reset together
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) rst_pipe <= 2'b00;
        else        rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_sync_b = rst_pipe[1];

    // ------------------------------------------------------------
    // Beat buffer
    // ------------------------------------------------------------
    css_beat_t head;
    logic      head_valid;
    logic      head_ready;
    logic      load;

    css_fifo #(
        .W     ($bits(css_beat_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock      (clock),
        .rst_sync_b (rst_sync_b),
        .in_valid   (in_valid),
        .in_ready   (in_ready),
        .in_data    (in_beat),
        .out_valid  (head_valid),
        .out_ready  (head_ready),
        .out_data   (head)
    );

    // Output register refills only when empty or being emptied [RL1] [RL2]
    assign head_ready = !cpl_out_valid || cpl_out_ready;
    assign load       = head_valid && head_ready;

    // ------------------------------------------------------------
    // Framing state
    // ------------------------------------------------------------
    css_state_t state;
    css_state_t next_state;
    logic       open_now;
    logic       sof0_eff;
    logic       sof1_eff;
    logic [5:0] desc0_lo;

    assign open_now = (state == ST_BODY);

    // First start flag follows packet position without straddle [RL9]
    assign sof0_eff = STRAD_ON ? head.sof0 : !open_now;                    // [RL9]
    // Second start only straddled, and only after the first TLP ended [RL10] [RL14]
    assign sof1_eff = STRAD_ON && head.sof1 && head.eof0[0];              // [RL10] [RL14]
    // A straddled first start sits at lane 16 while the prior TLP continues
    assign desc0_lo = (STRAD_ON && open_now) ? 6'(STRADDLE_LANE) : 6'h00; // [RL13]

    // Track whether a TLP remains open after the loaded beat
    always_comb begin
        next_state = state;
        if (!STRAD_ON) begin
            next_state = head.last ? ST_START : ST_BODY;
        end else if (sof1_eff) begin
            next_state = head.eof1[0] ? ST_START : ST_BODY;
        end else if (open_now) begin
            if (head.eof0[0]) begin
                next_state = (head.sof0 && !head.eof1[0]) ? ST_BODY : ST_START;
            end
        end else if (head.sof0) begin
            next_state = head.eof0[0] ? ST_START : ST_BODY;
        end
    end

    // State moves with beats entering the output register
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= ST_START;
        end else if (load) begin
            case (state)
                ST_START: state <= next_state;
                ST_BODY:  state <= next_state;
                default:  state <= ST_START;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-byte enables, data and parity
    // ------------------------------------------------------------
    logic [MAX_BYTES-1:0]  be_next;
    logic [MAX_BYTES-1:0]  par_next;
    logic [MAX_DATA_W-1:0] data_next;

    for (genvar i = 0; i < MAX_BYTES; i++) begin : g_byte
        logic run0;
        logic run1;
        logic desc;
        // Payload runs come as first/last byte pairs, so each is contiguous [RL6]
        assign run0 = head.pay0_en && (5'(i) >= head.pay0_lo) && (5'(i) <= head.pay0_hi);
        assign run1 = STRAD_ON && head.pay1_en
                      && (5'(i) >= head.pay1_lo) && (5'(i) <= head.pay1_hi);
        // Descriptor bytes of any TLP starting here are never enabled [RL5]
        assign desc = (sof0_eff && (6'(i) >= desc0_lo)
                          && (6'(i) < desc0_lo + 6'(DESC_BYTES)))
                      || (sof1_eff && (i >= STRADDLE_LANE)
                          && (i < STRADDLE_LANE + DESC_BYTES));
        // Lanes beyond the configured width stay zero [RL4] [RL7]
        if (i < BYTES) begin : g_live
            assign be_next[i]          = (run0 || run1) && !desc;          // [RL4] [RL8]
            assign data_next[8*i +: 8] = head.data[8*i +: 8];
            assign par_next[i]         = ~^head.data[8*i +: 8];
        end else begin : g_dead
            assign be_next[i]          = 1'b0;                             // [RL7]
            assign data_next[8*i +: 8] = 8'h00;
            assign par_next[i]         = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sideband and keep assembly
    // ------------------------------------------------------------
    css_sband_t sb_next;
    logic [7:0] keep_next;

    always_comb begin
        sb_next             = '0;
        sb_next.byte_en     = be_next;                                     // [RL4]
        sb_next.sof0        = sof0_eff;
        sb_next.sof1        = sof1_eff;                                    // [RL10]
        // End fields are reserved zeros unless straddling [RL17]
        sb_next.eof0        = STRAD_ON ? head.eof0 : 4'h0;                 // [RL17]
        sb_next.eof1        = sof1_eff ? head.eof1 : 4'h0;
        sb_next.discontinue = 1'b0;
        sb_next.parity      = par_next;
    end

    // Straddled beats are not stream packets, so keep is all ones [RL12]
    always_comb begin
        keep_next = KEEP_NONE;
        for (int d = 0; d < DWORDS; d++) keep_next[d] = head.keep[d];
        if (STRAD_ON) keep_next = KEEP_ALL;
    end

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    // Valid rises as soon as a beat waits and falls only after a handshake [RL15]
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cpl_out_valid <= 1'b0;
        end else if (load) begin
            cpl_out_valid <= 1'b1;                                         // [RL15]
        end else if (cpl_out_ready) begin
            cpl_out_valid <= 1'b0;                                         // [RL1]
        end
    end

    // Payload and sideband change only on load, so a stall holds them [RL2]
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cpl_out_payload_bus <= '0;
            cpl_out_keep        <= KEEP_NONE;
            cpl_out_last        <= 1'b0;
            cpl_out_sideband    <= '0;
        end else if (load) begin                                           // [RL2]
            cpl_out_payload_bus <= data_next;
            cpl_out_keep        <= keep_next;
            cpl_out_last        <= STRAD_ON ? 1'b0 : head.last;
            cpl_out_sideband    <= sb_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_sync_b);

    logic [MAX_BYTES:0] be_low;
    logic [MAX_BYTES:0] be_sum;
    assign be_low = {1'b0, cpl_out_sideband.byte_en}
                    & (~{1'b0, cpl_out_sideband.byte_en} + 33'h000000001);
    assign be_sum = {1'b0, cpl_out_sideband.byte_en} + be_low;

    sequence s_stalled;
        cpl_out_valid && !cpl_out_ready;
    endsequence
    sequence s_pkt_end;
        cpl_out_valid && cpl_out_ready && cpl_out_last;
    endsequence

    chk_stall_holds: assert property (s_stalled |=> cpl_out_valid          // [RL2]
        && $stable(cpl_out_payload_bus) && $stable(cpl_out_sideband))
        else $error("output changed during stall");
    chk_be_width: assert property (cpl_out_valid |->                      // [RL7]
        ((cpl_out_sideband.byte_en >> BYTES) == '0))
        else $error("byte enable above configured width");
    chk_sof1_zero: assert property (!STRAD_ON |->                         // [RL10]
        !cpl_out_sideband.sof1 && (cpl_out_sideband.eof1 == 4'h0))
        else $error("second start flag without straddle");
    chk_sof1_after_eof: assert property (cpl_out_valid                    // [RL14]
        && cpl_out_sideband.sof1 |-> cpl_out_sideband.eof0[0])
        else $error("second start without first end");
    chk_sof0_first: assert property (s_pkt_end ##1 (!STRAD_ON && cpl_out_valid) // [RL9]
        |-> cpl_out_sideband.sof0)
        else $error("packet start not flagged");
    chk_be_contig: assert property (!STRAD_ON && cpl_out_valid |->        // [RL6]
        ((be_sum & {1'b0, cpl_out_sideband.byte_en}) == '0))
        else $error("byte enables not contiguous");
    chk_desc_clear: assert property (!STRAD_ON && cpl_out_valid           // [RL5]
        && cpl_out_sideband.sof0 |-> (cpl_out_sideband.byte_en[DESC_BYTES-1:0] == '0))
        else $error("byte enable on descriptor");
    chk_valid_rises: assert property (head_valid && !cpl_out_valid        // [RL15]
        |=> cpl_out_valid ##0 $past(head_valid))
        else $error("waiting beat not presented");
    chk_pay_enable: assert property (load && !STRAD_ON && head.pay0_en    // [RL8]
        && (head.pay0_lo >= 5'(DESC_BYTES)) && (head.pay0_lo <= head.pay0_hi)
        && (int'(head.pay0_lo) < BYTES) |=> (cpl_out_sideband.byte_en != '0))
        else $error("payload beat without byte enable");
    chk_eof_reserved: assert property (!STRAD_ON |->                      // [RL17]
        (cpl_out_sideband.eof0 == 4'h0) && ((cpl_out_keep >> DWORDS) == '0))
        else $error("end field used without straddle");

endmodule // css_framer

// ---- hw/css_pkg.sv ----
// Shared types and constants for the completion stream output stage.
// Assumes a single user clock; every consumer imports css_pkg::*.
package css_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int MAX_DATA_W     = 256;          // Widest data bus
    localparam int MAX_BYTES      = 32;           // Byte lanes on widest bus
    localparam int MAX_DWORDS     = 8;            // Dword lanes on widest bus
    localparam int DEF_DATA_W     = 256;          // Default configured width
    localparam int FIFO_DEPTH     = 8;            // Beats buffered ahead of output
    localparam int STRADDLE_LANE  = 16;           // Byte lane of a straddled start
    localparam int DESC_BYTES     = 12;           // Completion descriptor length

    // ------------------------------------------------------------
    // Sideband field positions
    // ------------------------------------------------------------
    localparam int SB_BYTE_EN_LO  = 0;            // Byte enables 31:0
    localparam int SB_SOF0        = 32;           // First start flag
    localparam int SB_SOF1        = 33;           // Second start flag
    localparam int SB_EOF0_LO     = 34;           // First end field 37:34
    localparam int SB_EOF1_LO     = 38;           // Second end field 41:38
    localparam int SB_DISCONT     = 42;           // Discontinue flag
    localparam int SB_PARITY_LO   = 43;           // Byte parity 74:43
    localparam int SB_W           = 75;           // Sideband width

    // ------------------------------------------------------------
    // Keep values
    // ------------------------------------------------------------
    localparam logic [7:0] KEEP_ALL  = 8'hFF;     // Keep in straddle mode
    localparam logic [7:0] KEEP_NONE = 8'h00;     // Keep loaded by reset

    // Beat handed in by the completion engine
    typedef struct packed {
        logic [MAX_DATA_W-1:0] data;              // Raw beat data
        logic [7:0]            keep;              // Dword keep
        logic                  last;              // End of packet (no straddle)
        logic                  sof0;              // First TLP starts (straddle)
        logic                  sof1;              // Second TLP starts (straddle)
        logic [3:0]            eof0;              // First TLP end + offset
        logic [3:0]            eof1;              // Second TLP end + offset
        logic                  pay0_en;           // First payload run present
        logic [4:0]            pay0_lo;           // First payload first byte
        logic [4:0]            pay0_hi;           // First payload last byte
        logic                  pay1_en;           // Second payload run present
        logic [4:0]            pay1_lo;           // Second payload first byte
        logic [4:0]            pay1_hi;           // Second payload last byte
    } css_beat_t;

    // Sideband word, most significant field first
    typedef struct packed {
        logic [31:0] parity;                      // Odd parity per byte
        logic        discontinue;                 // Never raised by this stage
        logic [3:0]  eof1;                        // Second end field
        logic [3:0]  eof0;                        // First end field
        logic        sof1;                        // Second start flag
        logic        sof0;                        // First start flag
        logic [31:0] byte_en;                     // Payload byte enables
    } css_sband_t;

    // Output stage framing state
    typedef enum logic {
        ST_START,                                 // No TLP open across beats
        ST_BODY                                   // A TLP continues into next beat
    } css_state_t;

endpackage

// ---- test/css_framer_tb.sv ----
// Self-checking bench for css_framer at 256 bits, without and with straddle.
// Assumes css_sink consumes the output; inputs change on the falling edge.
`timescale 1ns/1ps
module css_framer_tb;
    import css_pkg::*;
    logic         clock, rst_b, in_valid, in_ready, hold_off, rdy, vld, last, exp_sof;
    logic         in_valid2, in_ready2, vld2, last2;
    css_beat_t    beat;
    logic [255:0] bus, bus2;
    logic [7:0]   keep, keep2;
    css_sband_t   sb, sb2;
    int           error_cnt, total_checks;
    int           cyc = 0;

    css_framer #(.DATA_W(256), .STRADDLE(1'b0), .DEPTH(FIFO_DEPTH)) DUT (
        .clock(clock), .rst_b(rst_b), .in_valid(in_valid), .in_ready(in_ready),
        .in_beat(beat), .cpl_out_ready(rdy), .cpl_out_valid(vld),
        .cpl_out_payload_bus(bus), .cpl_out_keep(keep), .cpl_out_last(last),
        .cpl_out_sideband(sb));
    css_framer #(.DATA_W(256), .STRADDLE(1'b1), .DEPTH(FIFO_DEPTH)) DUT2 (
        .clock(clock), .rst_b(rst_b), .in_valid(in_valid2), .in_ready(in_ready2),
        .in_beat(beat), .cpl_out_ready(rdy), .cpl_out_valid(vld2),
        .cpl_out_payload_bus(bus2), .cpl_out_keep(keep2), .cpl_out_last(last2),
        .cpl_out_sideband(sb2));
    css_sink SNK (.clock(clock), .hold_off(hold_off), .valid(vld), .data(bus),
        .last(last), .sband(sb), .ready(rdy));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Payload run minus the descriptor bytes that open a packet
    function automatic logic [31:0] exp_be(input int lo, input int hi, input logic s);
        logic [31:0] m;
        for (int i = 0; i < 32; i++) m[i] = (i >= lo) && (i <= hi) && !(s && i < DESC_BYTES);
        return m;
    endfunction

    // Engine sof1 is set on purpose: the stage must never pass it here
    function automatic css_beat_t mk(input int tag, input logic lst, input int lo, input int hi);
        css_beat_t b;
        b = '0;
        b.data[31:0] = tag;
        b.last = lst;
        b.keep = 8'hFF;
        b.sof1 = 1'b1;
        b.pay0_en = 1'b1;
        b.pay0_lo = lo[4:0];
        b.pay0_hi = hi[4:0];
        return b;
    endfunction

    task automatic send(input css_beat_t b, input bit two = 1'b0);
        int n;
        n = 0;
        beat = b;
        if (two) in_valid2 = 1'b1;
        else in_valid = 1'b1;
        while ((two ? in_ready2 : in_ready) !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
    endtask

    task automatic rx(input int tag, input logic lst, input int lo, input int hi);
        logic [107:0] r;
        css_sband_t   s;
        int           n;
        n = 0;
        while (SNK.rxq.size() == 0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        if (SNK.rxq.size() == 0) begin
            chk("beat arrived", 1, 0);
        end else begin
            r = SNK.rxq.pop_front();
            s = r[74:0];
            chk("data tag", tag, r[107:76]);
            chk("last", {31'b0, lst}, {31'b0, r[75]});
            chk("byte_en", exp_be(lo, hi, exp_sof), s.byte_en);
            chk("first start", {31'b0, exp_sof}, {31'b0, s.sof0});
            chk("second start", 0, {31'b0, s.sof1});
            chk("end fields", 0, {23'b0, s.eof1, s.eof0, s.discontinue});
            chk("parity", {28'hFFFFFFF, ~^tag[31:24], ~^tag[23:16], ~^tag[15:8],
                ~^tag[7:0]}, s.parity);
            exp_sof = lst;
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Back to back: two-beat packet, a zero-length read answer, a full run
    task automatic t_packets;
        send(mk(1, 1'b0, 4, 31));
        send(mk(2, 1'b1, 0, 9));
        send(mk(3, 1'b1, 12, 12));
        send(mk(4, 1'b1, 0, 31));
        in_valid = 1'b0;
        rx(1, 1'b0, 4, 31);
        rx(2, 1'b1, 0, 9);
        rx(3, 1'b1, 12, 12);
        rx(4, 1'b1, 0, 31);
    endtask

    // Ready low while valid is up: bus and sideband must stand still
    task automatic t_stall;
        logic [31:0] tag0, be0;
        hold_off = 1'b1;
        send(mk(5, 1'b1, 12, 20));
        in_valid = 1'b0;
        repeat (2) @(negedge clock);
        tag0 = bus[31:0];
        be0 = sb.byte_en;
        repeat (4) begin
            @(negedge clock);
            chk("held valid", 1, {31'b0, vld});
            chk("held tag", tag0, bus[31:0]);
            chk("held byte_en", be0, sb.byte_en);
            chk("held keep", 32'hFF, {24'b0, keep});
            chk("no take", 0, SNK.rxq.size());
        end
        hold_off = 1'b0;
        rx(5, 1'b1, 12, 20);
    endtask

    // Fill the buffer against a stalled consumer until refused, then drain
    task automatic t_fill;
        int n;
        n = 0;
        hold_off = 1'b1;
        in_valid = 1'b1;
        repeat (14) begin
            beat = mk(16 + n, 1'b1, 12, 15);
            if (in_ready === 1'b1) n++;
            @(negedge clock);
        end
        chk("refused", 0, {31'b0, in_ready});
        in_valid = 1'b0;
        hold_off = 1'b0;
        for (int i = 0; i < n; i++) rx(16 + i, 1'b1, 12, 15);
        repeat (3) @(negedge clock);
        chk("drained", 0, {31'b0, vld});
        chk("nothing extra", 0, SNK.rxq.size());
    endtask

    // Straddle: two TLPs share a beat, then a start at lane 16 behind an open TLP
    task automatic t_straddle;
        css_beat_t b;
        hold_off = 1'b1;
        b = mk(32, 1'b0, 12, 15);
        b.sof0 = 1'b1;
        b.eof0 = 4'h7;
        b.pay1_en = 1'b1;
        b.pay1_lo = 5'h1C;
        b.pay1_hi = 5'h1F;
        send(b, 1'b1);
        b = mk(33, 1'b0, 0, 7);
        b.sof0 = 1'b1;
        b.sof1 = 1'b0;
        b.eof0 = 4'h3;
        b.pay1_en = 1'b1;
        b.pay1_lo = 5'h10;
        b.pay1_hi = 5'h1F;
        send(b, 1'b1);
        in_valid2 = 1'b0;
        chk("strad tag", 32, bus2[31:0]);
        chk("strad byte_en", 32'hF000F000, sb2.byte_en);
        chk("strad flags", 32'h1F, {22'b0, sb2[41:32]});
        chk("strad valid keep last", 32'h3FE, {22'b0, vld2, keep2, last2});
        hold_off = 1'b0;
        @(negedge clock);
        hold_off = 1'b1;
        chk("strad tag", 33, bus2[31:0]);
        chk("strad byte_en", 32'hF00000FF, sb2.byte_en);
        chk("strad flags", 32'h0D, {22'b0, sb2[41:32]});
        hold_off = 1'b0;
        repeat (2) @(negedge clock);
        chk("strad drained", 0, {31'b0, vld2});
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // The whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            end_sim;
        end
    end

    initial begin
        rst_b = 1'b0;
        in_valid = 1'b0;
        in_valid2 = 1'b0;
        beat = '0;
        hold_off = 1'b0;
        exp_sof = 1'b1;
        error_cnt = 0;
        total_checks = 0;
        repeat (5) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        repeat (3) @(negedge clock);
        t_packets;
        t_stall;
        t_fill;
        t_straddle;
        end_sim;
    end
endmodule // css_framer_tb

// ---- test/css_sink.sv ----
// User-side consumer model for the completion stream output stage.
// Assumes the bench sets hold_off on the falling edge; ready follows it at once.
`timescale 1ns/1ps
module css_sink
    import css_pkg::*;
(
    input  wire logic                clock,    // User clock
    input  wire logic                hold_off, // Bench asks for a stall
    input  wire logic                valid,    // Beat on the bus
    input  wire logic [255:0]        data,     // Data bus
    input  wire logic                last,     // End of packet
    input  wire css_pkg::css_sband_t sband,    // Sideband word
    output logic                     ready     // Consumer accepts
);
    logic [107:0] rxq[$];                      // Tag, last, sideband of each beat taken

    // Pacing comes from the bench, so a stall can be held as long as a test needs
    assign ready = !hold_off;

    // Take a beat only on a handshake edge; bounds come from last, not sof0
    always @(posedge clock) begin
        if (valid === 1'b1 && ready === 1'b1) begin
            rxq.push_back({data[31:0], last, sband});
        end
    end
endmodule // css_sink
